// ---- rtl/adf_filter_ctrl.sv ----
// Purpose: Decimation filter control, rate and settling sequencer
// Assumes: Modulator and low-power clocks arrive as asynchronous pins
// Notes: One APB wait state; output periods counted in modulator ticks
`timescale 1ns/1ps
module adf_filter_ctrl
  import adf_pkg::*;
#(
  parameter int STARTUP_CYC = adf_pkg::ADF_STARTUP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the analog side
  input wire logic modClkPin,
  input wire logic lpOscPin,
  input wire logic lowPowerPin,
  // Converter enables from core logic
  input wire logic priActive,
  input wire logic auxActive,
  // Filter and converter controls
  output logic adcReset,
  output logic chopOn,
  output logic runAvgOn,
  output logic secondNotchOn,
  output logic [7:0] extConfig,
  output logic resultValid,
  output logic settled
);
  import adf_pkg::*;

  localparam int PW = ADF_PERIOD_W;
  localparam logic [13:0] N60 = 14'(ADF_NORM_MOD_HZ / ADF_FORCED_A_HZ);
  localparam logic [13:0] N50 = 14'(ADF_NORM_MOD_HZ / ADF_FORCED_B_HZ);
  localparam logic [13:0] L60 = 14'(ADF_LP_MOD_HZ / ADF_FORCED_A_HZ);
  localparam logic [13:0] L50 = 14'(ADF_LP_MOD_HZ / ADF_FORCED_B_HZ);
  localparam logic [PW-1:0] NMAX = PW'(ADF_NORM_MOD_HZ / ADF_MIN_NORM_HZ);
  localparam logic [PW-1:0] LMAX = PW'(ADF_LP_MOD_HZ / ADF_MIN_LP_HZ);

  if (STARTUP_CYC < 1 || STARTUP_CYC > 32767)
  begin : g_chk
    $error("adf_filter_ctrl: STARTUP_CYC out of range");
  end

  // Legal SF/AF pairing, used by the status word only
  function automatic logic comboLegal(input logic [6:0] sf,
                                      input logic [5:0] af);
    comboLegal = (sf < 7'd32) || (sf < 7'd64 && af < 6'd8) ||
                 (af == 6'h00);
  endfunction : comboLegal

  // Pin synchronisers, 3 stages plus agreed level
  logic [2:0] pinRaw;
  logic [2:0] pinS1_q;
  logic [2:0] pinS2_q;
  logic [2:0] pinS3_q;
  logic [2:0] pinLvl_q;
  logic [2:0] pinRise;
  assign pinRaw = {lowPowerPin, lpOscPin, modClkPin};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        pinS1_q[i] <= 1'b0;
        pinS2_q[i] <= 1'b0;
        pinS3_q[i] <= 1'b0;
        pinLvl_q[i] <= 1'b0;
      end
      else
      begin
        pinS1_q[i] <= pinRaw[i];
        pinS2_q[i] <= pinS1_q[i];
        pinS3_q[i] <= pinS2_q[i];
        if (pinS2_q[i] == pinS3_q[i])
          pinLvl_q[i] <= pinS3_q[i];
      end
    end
    assign pinRise[i] = (pinS2_q[i] == pinS3_q[i]) && pinS3_q[i] &&
                        !pinLvl_q[i];
  end

  wire lowPower = pinLvl_q[2];
  wire lpChange = (pinS2_q[2] == pinS3_q[2]) &&
                  (pinS3_q[2] != pinLvl_q[2]);
  wire modTick = lowPower ? pinRise[1] : pinRise[0];

  // APB decode; one wait state so prdata leaves a flop
  logic [15:0] filtCtrl_q;
  logic [7:0] extCfg_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdData;
  wire hitCtrl = (paddr == ADF_FILT_CTRL_ADDR);
  wire hitExt = (paddr == ADF_EXT_CFG_ADDR);
  wire hitStat = (paddr == ADF_STATUS_ADDR);
  wire mapped = hitCtrl || hitExt || hitStat;
  wire accessNow = psel && penable && !pready_q;
  wire commit = psel && penable && pready_q;
  wire wrCtrl = commit && pwrite && hitCtrl && (pstrb[1:0] != 2'b00);
  wire wrExt = commit && pwrite && hitExt && pstrb[0];
  logic [15:0] ctrlMerged;
  assign ctrlMerged[7:0] = pstrb[0] ? pwdata[7:0] : filtCtrl_q[7:0];
  assign ctrlMerged[15:8] = pstrb[1] ? pwdata[15:8] : filtCtrl_q[15:8];

  // Field decode
  wire [6:0] sf = filtCtrl_q[ADF_SF_MSB:0];
  wire [5:0] af = filtCtrl_q[ADF_AF_MSB:ADF_AF_LSB];
  wire chopBit = filtCtrl_q[ADF_CHOP_BIT];
  wire afOn = (af != 6'h00);
  wire ravgEff = filtCtrl_q[ADF_RAVG_BIT] || chopBit;

  // base sinc3 period in modulator ticks
  wire [13:0] sfPlus = {7'h00, sf} + 14'h0001;
  wire [13:0] baseFormula = 14'(sfPlus * 14'(ADF_OSR));
  // forced 60 Hz and 50 Hz periods
  wire [13:0] base60 = lowPower ? L60 : N60;
  wire [13:0] base50 = lowPower ? L50 : N50;
  wire [13:0] baseTicks = (sf == 7'(ADF_SF_60HZ)) ? base60 :
                          (sf == 7'(ADF_SF_50HZ)) ? base50 : baseFormula;
  // post filter divides by 3 plus factor
  wire [6:0] afMult = {1'b0, af} + 7'(ADF_AF_OFFSET);
  wire [PW-1:0] scaled = PW'(PW'(baseTicks) * PW'(afMult));
  // chop adds three ticks to scaled period
  wire [PW-1:0] chopPer = scaled + PW'(ADF_CHOP_EXTRA);
  // running average leaves rate unchanged; chop and AF set it
  wire [PW-1:0] rawPer = chopBit ? chopPer :
                         afOn ? scaled : PW'(baseTicks);
  wire [PW-1:0] maxPer = lowPower ? LMAX : NMAX;
  wire [PW-1:0] periodD = (rawPer > maxPer) ? maxPer : rawPer;

  wire [2:0] settleD = chopBit ? 3'(ADF_SETTLE_CHOP) :
                       afOn ? (ravgEff ? 3'(ADF_SETTLE_AF_RAVG) :
                                         3'(ADF_SETTLE_AF)) :
                       (ravgEff ? 3'(ADF_SETTLE_RAVG) :
                                  3'(ADF_SETTLE_PLAIN));

  wire [1:0] nActive = {1'b0, priActive} + {1'b0, auxActive};
  wire [15:0] waitTarget = 16'(STARTUP_CYC) * {14'h0000, nActive};

  // Register file and APB response
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      filtCtrl_q <= ADF_FILT_CTRL_RST;
      extCfg_q <= ADF_EXT_CFG_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= accessNow;
      pslverr_q <= accessNow && !mapped;
      if (accessNow)
        prdata_q <= rdData;
      if (wrCtrl)
        filtCtrl_q <= ctrlMerged;
      if (wrExt)
        extCfg_q <= pwdata[7:0];
    end
  end

  // Sequencer
  adf_state_t state_q;
  adf_state_t state_d;
  logic [15:0] waitCnt_q;
  logic [2:0] settleCnt_q;
  logic [2:0] settleTgt_q;
  logic [PW-1:0] period_q;
  logic adcReset_q;
  logic valid_q;
  logic chopOn_q;
  logic ravgOn_q;
  logic notch_q;
  logic periodDone;
  logic settled_q;
  // Restart after reset, control write or power mode change
  wire restartSeq = adcReset_q || lpChange;
  wire timerHold = (state_q != ADF_ST_SETTLE) && (state_q != ADF_ST_RUN);
  wire lastSettle = periodDone && (settleCnt_q + 3'h1 >= settleTgt_q);

  adf_period_timer #(
    .W(PW)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .restart(timerHold || restartSeq),
    .tick(modTick),
    .period(period_q),
    .done(periodDone)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ADF_ST_WAIT:
        if (nActive == 2'b00)
          state_d = ADF_ST_IDLE;
        else if (waitCnt_q + 16'h0001 >= waitTarget)
          state_d = ADF_ST_SETTLE;
      ADF_ST_SETTLE:
        if (lastSettle)
          state_d = ADF_ST_RUN;
      ADF_ST_RUN:
        if (nActive == 2'b00)
          state_d = ADF_ST_IDLE;
      ADF_ST_IDLE:
        if (nActive != 2'b00)
          state_d = ADF_ST_WAIT;
      default:
        state_d = ADF_ST_WAIT;
    endcase
    if (restartSeq)
      state_d = ADF_ST_WAIT;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ADF_ST_WAIT;
      waitCnt_q <= 16'h0000;
      settleCnt_q <= 3'h0;
      settleTgt_q <= 3'(ADF_SETTLE_PLAIN);
      period_q <= PW'(1);
      valid_q <= 1'b0;
      settled_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      settled_q <= (state_d == ADF_ST_RUN);
      period_q <= periodD;
      settleTgt_q <= settleD;
      waitCnt_q <= (state_q == ADF_ST_WAIT && !restartSeq) ?
                   waitCnt_q + 16'h0001 : 16'h0000;
      if (state_q != ADF_ST_SETTLE || restartSeq)
        settleCnt_q <= 3'h0;
      else if (periodDone)
        settleCnt_q <= settleCnt_q + 3'h1;
      // one strobe per sample once settled
      valid_q <= !restartSeq && periodDone &&
                 ((state_q == ADF_ST_RUN) ||
                  (state_q == ADF_ST_SETTLE && lastSettle));
    end
  end

  // Converter controls
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      adcReset_q <= 1'b0;
      chopOn_q <= 1'b0;
      ravgOn_q <= 1'b0;
      notch_q <= 1'b0;
    end
    else
    begin
      // a control write touching byte lane 0 or 1 resets both converters
      adcReset_q <= wrCtrl;
      chopOn_q <= chopBit;
      ravgOn_q <= ravgEff;
      notch_q <= filtCtrl_q[ADF_NOTCH_BIT];
    end
  end

  // Read mux; status shows sequencer and legality
  wire [31:0] statusWord = {16'h0000, 4'(state_q), 1'b0,
                            settleCnt_q, 3'h0, lowPower, 1'b0,
                            comboLegal(sf, af), ravgEff,
                            (state_q == ADF_ST_RUN)};
  assign rdData = hitCtrl ? {16'h0000, filtCtrl_q} :
                  hitExt ? {24'h000000, extCfg_q} :
                  hitStat ? statusWord : 32'h00000000;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign adcReset = adcReset_q;
  assign chopOn = chopOn_q;
  assign runAvgOn = ravgOn_q;
  assign secondNotchOn = notch_q;
  assign extConfig = extCfg_q;
  assign resultValid = valid_q;
  assign settled = settled_q;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_ctrl_write;
    psel && penable && pready && pwrite &&
    (paddr == ADF_FILT_CTRL_ADDR) && (pstrb[1:0] != 2'b00);
  endsequence
  sequence s_quiet;
    !resultValid [*3];
  endsequence

  property p_write_reset;
    s_ctrl_write |=> adcReset ##1 (!adcReset and s_quiet);
  endproperty
  a_write_reset: assert property (p_write_reset)
    else $error("control write did not reset converters");

  property p_chop_ravg;
    chopOn |-> runAvgOn;
  endproperty
  a_chop_ravg: assert property (p_chop_ravg)
    else $error("running average off while chopping");

  property p_chop_rate;
    chopBit && sf < 7'd126 && $stable(filtCtrl_q) && $stable(lowPower)
      |-> period_q == (PW'(sf) + PW'(1)) * PW'(ADF_OSR) *
          (PW'(af) + PW'(ADF_AF_OFFSET)) + PW'(ADF_CHOP_EXTRA) ||
          period_q == maxPer;
  endproperty
  a_chop_rate: assert property (p_chop_rate)
    else $error("chop period wrong");

  property p_af_rate;
    !chopBit && afOn && sf < 7'd126 && $stable(filtCtrl_q) &&
      $stable(lowPower)
      |-> period_q == (PW'(sf) + PW'(1)) * PW'(ADF_OSR) *
          (PW'(af) + PW'(ADF_AF_OFFSET)) ||
          period_q == maxPer;
  endproperty
  a_af_rate: assert property (p_af_rate)
    else $error("averaged period wrong");

  property p_forced60;
    (sf == 7'd126) && !chopBit && !afOn && !lowPower
      && $stable(filtCtrl_q) && $stable(lowPower)
      |-> period_q == PW'(8533);
  endproperty
  a_forced60: assert property (p_forced60)
    else $error("60 Hz period wrong");

  property p_slowest;
    period_q <= (lowPower ? PW'(131072) : PW'(128000)) ||
      $changed(lowPower);
  endproperty
  a_slowest: assert property (p_slowest)
    else $error("period beyond slowest rate");

  property p_settle_plain;
    !chopBit && !afOn && !ravgEff && $stable(filtCtrl_q)
      |=> settleTgt_q == 3'd3;
  endproperty
  a_settle_plain: assert property (p_settle_plain)
    else $error("settling count wrong");

  property p_valid_gap;
    resultValid |=> !resultValid ##1 !resultValid;
  endproperty
  a_valid_gap: assert property (p_valid_gap)
    else $error("valid strobe too long");

  property p_startup;
    $rose(state_q == ADF_ST_SETTLE) |->
      $past(waitCnt_q) + 16'h0001 >= $past(waitTarget);
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up wait cut short");
endmodule : adf_filter_ctrl

// ---- rtl/adf_period_timer.sv ----
// Purpose: Counts modulator ticks into filter output periods
// Assumes: tick is a one-cycle strobe in the core clock domain
// Notes: done pulses for one cycle at the end of each period
`timescale 1ns/1ps
module adf_period_timer #(
  parameter int W = 21
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic tick,
  input wire logic [W-1:0] period,
  // Result
  output logic done
);
  logic [W-1:0] cnt_q;
  logic done_q;
  wire lastTick = tick && ({1'b0, cnt_q} + 1'b1 >= {1'b0, period});

  if (W < 2)
  begin : g_chk
    $error("adf_period_timer: W too small");
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= lastTick && !restart;
      if (restart || lastTick)
        cnt_q <= '0;
      else if (tick)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = done_q;
endmodule : adf_period_timer

// ---- rtl/adf_pkg.sv ----
// Purpose: Shared constants for the ADC decimation filter control block
// Assumes: 100 MHz core clock, APB register access
// Notes: Offsets are byte addresses on the APB bus
package adf_pkg;
  localparam logic [31:0] ADF_FILT_CTRL_ADDR = 32'hffff0514;
  localparam logic [31:0] ADF_EXT_CFG_ADDR = 32'hffff0518;
  localparam logic [31:0] ADF_STATUS_ADDR = 32'hffff051c;
  localparam logic [15:0] ADF_FILT_CTRL_RST = 16'h0007;
  localparam logic [7:0] ADF_EXT_CFG_RST = 8'h00;
  // Filter control field positions
  localparam int ADF_CHOP_BIT = 15;
  localparam int ADF_RAVG_BIT = 14;
  localparam int ADF_AF_MSB = 13;
  localparam int ADF_AF_LSB = 8;
  localparam int ADF_NOTCH_BIT = 7;
  localparam int ADF_SF_MSB = 6;
  // Rate figures
  localparam int ADF_OSR = 64;
  localparam int ADF_AF_OFFSET = 3;
  localparam int ADF_CHOP_EXTRA = 3;
  localparam int ADF_SF_60HZ = 126;
  localparam int ADF_SF_50HZ = 127;
  localparam int ADF_NORM_MOD_HZ = 512000;
  localparam int ADF_LP_MOD_HZ = 131072;
  localparam int ADF_FORCED_A_HZ = 60;
  localparam int ADF_FORCED_B_HZ = 50;
  localparam int ADF_MIN_NORM_HZ = 4;
  localparam int ADF_MIN_LP_HZ = 1;
  // Settling in output periods
  localparam int ADF_SETTLE_PLAIN = 3;
  localparam int ADF_SETTLE_RAVG = 4;
  localparam int ADF_SETTLE_AF = 1;
  localparam int ADF_SETTLE_AF_RAVG = 2;
  localparam int ADF_SETTLE_CHOP = 2;
  // Start-up delay per active converter
  localparam int ADF_STARTUP_US = 60;
  localparam int ADF_CLK_MHZ = 100;
  localparam int ADF_STARTUP_CYC = ADF_STARTUP_US * ADF_CLK_MHZ;
  localparam int ADF_PERIOD_W = 21;
  typedef enum logic [3:0] {
    ADF_ST_WAIT = 4'b0001,
    ADF_ST_SETTLE = 4'b0010,
    ADF_ST_RUN = 4'b0100,
    ADF_ST_IDLE = 4'b1000
  } adf_state_t;
endpackage : adf_pkg

// ---- sim/adc_decimation_filter_control_tb.sv ----
// Purpose: Self-checking bench for the filter control block
// Assumes: Short start-up count of 20 cycles per converter
// Notes: Output periods are measured in source pin ticks
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module adc_decimation_filter_control_tb;
  import adf_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, lowPowerPin, priActive, auxActive;
  logic [31:0] paddr, pwdata, prdata, rnd;
  logic [3:0] pstrb;
  logic pready, pslverr, modClkPin, lpOscPin, adcReset, chopOn;
  logic runAvgOn, secondNotchOn, resultValid, settled, tickPrev;
  logic [7:0] extConfig;
  logic [33:0] busQ[$];
  logic [31:0] strQ[$];
  logic [33:0] bNote;
  logic [31:0] sNote;
  wire logic selPin;
  int err_total = 0;
  int comparisons = 0;
  int seed = 19;
  int adcCount = 0;
  int ticks = 0;
  int k, i;
  // only legal SF and AF pairings
  logic [15:0] cfgs [6] = '{16'h0000, 16'h4000, 16'h0200, 16'h4200,
    16'h8000, 16'h8280};
  int per [6] = '{64, 64, 320, 320, 195, 323};
  int stl [6] = '{3, 4, 1, 2, 2, 2};

  assign selPin = lowPowerPin ? lpOscPin : modClkPin;
  always #5 core_clk = ~core_clk;

  adf_filter_ctrl #(.STARTUP_CYC(20)) dut (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modClkPin(modClkPin), .lpOscPin(lpOscPin),
    .lowPowerPin(lowPowerPin), .priActive(priActive),
    .auxActive(auxActive), .adcReset(adcReset), .chopOn(chopOn),
    .runAvgOn(runAvgOn), .secondNotchOn(secondNotchOn),
    .extConfig(extConfig), .resultValid(resultValid), .settled(settled));

  adf_mod_source partner (.lowPower(lowPowerPin), .modClkPin(modClkPin),
    .lpOscPin(lpOscPin));

  // Bus answers against the oldest note
  always @(posedge core_clk)
  begin
    if (psel && penable && pready)
    begin
      bNote = busQ.pop_front();
      `CHK(pslverr, bNote[32])
      if (bNote[33])
        `CHK(prdata, bNote[31:0])
    end
  end

  // Ticks since reset pulse or last sample
  always @(posedge core_clk)
  begin
    if (selPin && !tickPrev)
      ticks = ticks + 1;
    tickPrev = selPin;
    if (adcReset)
    begin
      ticks = 0;
      adcCount++;
    end
    if (resultValid)
    begin
      if (strQ.size() == 0)
        `CHK(1'b0, 1'b1)
      else
      begin
        sNote = strQ.pop_front();
        `CHK(ticks >= sNote[31:16] && ticks <= sNote[15:0], 1'b1)
      end
      ticks = 0;
    end
  end

  task automatic apb(input logic wr, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic err,
    input logic [31:0] ex);
    @(posedge core_clk);
    busQ.push_back({~wr, err, ex});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // First sample after settling, then steady periods
  task automatic cfg(input logic [15:0] c, input int p, input int s,
    input int n);
    int r;
    r = adcCount;
    priActive <= 1'b0;
    auxActive <= 1'b0;
    apb(1'b1, ADF_FILT_CTRL_ADDR, {16'h0, c}, 4'hf, 1'b0, 32'h0);
    priActive <= 1'b1;
    auxActive <= 1'b1;
    strQ.push_back({16'(s * p), 16'(s * p + 16)});
    repeat (n) strQ.push_back({16'(p), 16'(p)});
    repeat (3) @(posedge core_clk);
    `CHK(adcCount, r + 1)
    `CHK(settled, 1'b0)
    `CHK(chopOn, c[ADF_CHOP_BIT])
    `CHK(runAvgOn, c[ADF_RAVG_BIT] | c[ADF_CHOP_BIT])
    `CHK(secondNotchOn, c[ADF_NOTCH_BIT])
    apb(1'b0, ADF_FILT_CTRL_ADDR, 32'h0, 4'h0, 1'b0, {16'h0, c});
    while (strQ.size() != 0)
      @(posedge core_clk);
    `CHK(settled, 1'b1)
  endtask : cfg

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (95000) @(posedge core_clk);
    err_total++;
    tally_and_finish;
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    lowPowerPin = 1'b0;
    priActive = 1'b1;
    auxActive = 1'b1;
    tickPrev = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, ADF_FILT_CTRL_ADDR, 32'h0, 4'h0, 1'b0, 32'h0007);
    apb(1'b0, ADF_EXT_CFG_ADDR, 32'h0, 4'h0, 1'b0, 32'h0);
    apb(1'b0, ADF_STATUS_ADDR + 32'h4, 32'h0, 4'h0, 1'b1, 32'h0);
    apb(1'b1, ADF_STATUS_ADDR + 32'h4, $random(seed), 4'hf, 1'b1, 32'h0);
    rnd = $random(seed);
    apb(1'b1, ADF_EXT_CFG_ADDR, rnd, 4'hf, 1'b0, 32'h0);
    apb(1'b0, ADF_EXT_CFG_ADDR, 32'h0, 4'h0, 1'b0, {24'h0, rnd[7:0]});
    `CHK(extConfig, rnd[7:0])
    // Upper lanes only: control left alone
    k = adcCount;
    apb(1'b1, ADF_FILT_CTRL_ADDR, $random(seed), 4'hc, 1'b0, 32'h0);
    apb(1'b0, ADF_FILT_CTRL_ADDR, 32'h0, 4'h0, 1'b0, 32'h0007);
    `CHK(adcCount, k)
    // forced 60 Hz period, normal power
    apb(1'b1, ADF_FILT_CTRL_ADDR, 32'h0000007e, 4'h3, 1'b0, 32'h0);
    apb(1'b0, ADF_STATUS_ADDR, 32'h0, 4'h0, 1'b0, 32'h00001004);
    `CHK(adcCount, k + 1)
    for (i = 0; i < 6; i++)
      cfg(cfgs[i], per[i], stl[i], 2);
    lowPowerPin <= 1'b1;
    repeat (20) @(posedge core_clk);
    cfg(16'h0001, 128, 3, 1);
    cfg(16'h007e, ADF_LP_MOD_HZ / ADF_FORCED_A_HZ, 3, 1);
    tally_and_finish;
  end
endmodule : adc_decimation_filter_control_tb

// ---- sim/adf_mod_source.sv ----
// Purpose: Modulator and low-power oscillator pins for the filter
// Assumes: Both pins change on falling edges of the core clock
// Notes: Modulator pin stands low while low-power mode is on
`timescale 1ns/1ps
module adf_mod_source (
  // Mode
  input wire logic lowPower,
  // Clock pins
  output logic modClkPin,
  output logic lpOscPin
);
  initial
  begin
    modClkPin = 1'b0;
    lpOscPin = 1'b0;
  end
  // slow source on its own pin
  always
  begin
    #30 lpOscPin = ~lpOscPin;
  end
  // Edges fall on falling core edges, between rising ones, no sampling race
  always
  begin
    #20 modClkPin = lowPower ? 1'b0 : ~modClkPin;
  end
endmodule : adf_mod_source
